// ==== include/bitctl_pkg.sv ====
// Constants and types for the bit and control instruction decoder
package bitctl_pkg;

  // ==========================================================
  // Widths and instruction field positions
  localparam int PC_W = 20;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int BITPOS_MSB = 11;
  localparam int BITPOS_LSB = 9;
  localparam int ACCESS_BIT = 8;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 8;
  localparam int LONG_SEL_BIT = 11;
  localparam int FAST_BIT = 0;
  localparam int CALL_FAST_BIT = 8;

  // ==========================================================
  // Upper nibble opcodes
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OPC_BIT_SET = 4'h8;
  localparam logic [3:0] OPC_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OPC_SKIP_CLEAR = 4'hB;
  localparam logic [3:0] OPC_SKIP_SET = 4'hA;
  localparam logic [3:0] OPC_COND_GROUP = 4'hE;
  localparam logic [3:0] OPC_REL_LONG = 4'hD;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
  localparam logic [3:0] OPC_ZERO_GROUP = 4'h0;

  // ==========================================================
  // Second nibble codes
  localparam logic [3:0] COND_ZERO = 4'h0;
  localparam logic [3:0] COND_NOT_ZERO = 4'h1;
  localparam logic [3:0] COND_CARRY = 4'h2;
  localparam logic [3:0] COND_NOT_CARRY = 4'h3;
  localparam logic [3:0] COND_OVERFLOW = 4'h4;
  localparam logic [3:0] COND_NOT_OVERFLOW = 4'h5;
  localparam logic [3:0] COND_NEGATIVE = 4'h6;
  localparam logic [3:0] COND_NOT_NEGATIVE = 4'h7;
  localparam logic [2:0] SUB_ABS_CALL = 3'h6;
  localparam logic [3:0] SUB_ABS_JUMP = 4'hF;
  localparam logic [3:0] SUB_LIT_RETURN = 4'hC;
  localparam logic [3:0] SUB_CONTROL = 4'h0;

  // ==========================================================
  // Low byte of the all-zero control group
  localparam logic [7:0] CTL_NOP = 8'h00;
  localparam logic [7:0] CTL_STANDBY = 8'h03;
  localparam logic [7:0] CTL_WDT_CLEAR = 8'h04;
  localparam logic [7:0] CTL_PUSH = 8'h05;
  localparam logic [7:0] CTL_POP = 8'h06;
  localparam logic [7:0] CTL_DECIMAL = 8'h07;
  localparam logic [7:0] CTL_INT_RETURN = 8'h10;
  localparam logic [7:0] CTL_INT_RETURN_FAST = 8'h11;
  localparam logic [7:0] CTL_SUB_RETURN = 8'h12;
  localparam logic [7:0] CTL_SUB_RETURN_FAST = 8'h13;
  localparam logic [7:0] CTL_SOFT_RESET = 8'hFF;

  // ==========================================================
  // Reset values
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic POWER_DOWN_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SECOND = 3'b010,
    ST_FLUSH = 3'b100
  } seq_state_type;

endpackage

// ==== include/dec_calc_if.sv ====
// Operand and target calculation link between decoder and its helpers
`timescale 1ns/1ps
interface dec_calc_if;
  import bitctl_pkg::*;
  logic [3:0] bitOpcode;
  logic [2:0] bitPos;
  logic [7:0] operand;
  logic [7:0] result;
  logic testedBit;
  logic [PC_W-1:0] basePc;
  logic [10:0] longOffset;
  logic [7:0] shortOffset;
  logic isLong;
  logic [PC_W-1:0] target;

  modport decoder (
    output bitOpcode, bitPos, operand, basePc, longOffset, shortOffset, isLong,
    input result, testedBit, target
  );
  modport bitUnit (
    input bitOpcode, bitPos, operand,
    output result, testedBit
  );
  modport branchUnit (
    input basePc, longOffset, shortOffset, isLong,
    output target
  );
endinterface

// ==== rtl/bit_op_unit.sv ====
// Single-bit clear, set, toggle and test on an 8-bit operand
`timescale 1ns/1ps
module bit_op_unit
  import bitctl_pkg::*;
(
  // Calculation link
  dec_calc_if.bitUnit calc
);

  logic [7:0] mask;

  always_comb begin
    mask = 8'h01 << calc.bitPos;
    calc.testedBit = |(calc.operand & mask);
    case (calc.bitOpcode)
      OPC_BIT_CLEAR: calc.result = calc.operand & ~mask;
      OPC_BIT_SET: calc.result = calc.operand | mask;
      OPC_BIT_TOGGLE: calc.result = calc.operand ^ mask;
      default: calc.result = calc.operand;
    endcase
  end

endmodule

// ==== rtl/branch_target_unit.sv ====
// Relative branch target from the following instruction address
`timescale 1ns/1ps
module branch_target_unit
  import bitctl_pkg::*;
(
  // Calculation link
  dec_calc_if.branchUnit calc
);

  logic [PC_W-1:0] extOffset;

  always_comb begin
    if (calc.isLong) begin
      extOffset = {{(PC_W-11){calc.longOffset[10]}}, calc.longOffset};
    end else begin
      extOffset = {{(PC_W-8){calc.shortOffset[7]}}, calc.shortOffset};
    end
    calc.target = PC_W'(calc.basePc + extOffset);
  end

endmodule

// ==== rtl/bit_and_control_op_decoder.sv ====
// Decoder and sequencer for bit-oriented and control-flow instructions
`timescale 1ns/1ps

module bit_and_control_op_decoder
  import bitctl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fetch side
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic [PC_W-1:0] nextPc,
  input wire logic [PC_W-1:0] stackTopData,
  // Status flags from the datapath
  input wire logic zeroFlag,
  input wire logic carryFlag,
  input wire logic overflowFlag,
  input wire logic negativeFlag,
  // File operand read
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] pinRdData,
  input wire logic fileIsPort,
  input wire logic fileIsTimerZero,
  input wire logic prescalerAssigned,
  // File access
  output logic [7:0] fileAddr,
  output logic accessBank,
  output logic fileRdEn,
  output logic fileWrEn,
  output logic [7:0] fileWrData,
  output logic prescalerClear,
  // Program counter and return stack
  output logic pcLoad,
  output logic [PC_W-1:0] pcTarget,
  output logic [PC_W-1:0] retAddr,
  output logic callPush,
  output logic fastSave,
  output logic returnPop,
  output logic fastRestore,
  output logic stackPushOp,
  output logic stackPopOp,
  // Working register and interrupt enables
  output logic wregWrEn,
  output logic [7:0] wregData,
  output logic irqEnableRestore,
  // System control
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic watchdogClear,
  output logic standbyEnter,
  output logic softReset,
  output logic decimalAdjust,
  output logic wordSquash
);

  // ==========================================================
  // State record
  typedef struct packed {
    seq_state_type state;
    logic execPend;
    logic [15:0] instr;
    logic [PC_W-1:0] nextPcHold;
    logic [7:0] lowTarget;
    logic isCall;
    logic fastSel;
    logic [7:0] fileAddr;
    logic accessBank;
    logic fileRdEn;
    logic fileWrEn;
    logic [7:0] fileWrData;
    logic prescalerClear;
    logic pcLoad;
    logic [PC_W-1:0] pcTarget;
    logic [PC_W-1:0] retAddr;
    logic callPush;
    logic fastSave;
    logic returnPop;
    logic fastRestore;
    logic stackPushOp;
    logic stackPopOp;
    logic wregWrEn;
    logic [7:0] wregData;
    logic irqEnableRestore;
    logic timeoutFlag;
    logic powerDownFlag;
    logic watchdogClear;
    logic standbyEnter;
    logic softReset;
    logic decimalAdjust;
    logic wordSquash;
  } dec_state_type;

  dec_state_type state_ff;
  dec_state_type nxt_state;
  logic condMet;
  logic [3:0] curOpc;
  logic [3:0] curSub;
  logic [3:0] newOpc;

  dec_calc_if calcIf ();

  // ==========================================================
  // Helpers
  bit_op_unit bitUnit (
    .calc(calcIf.bitUnit)
  );

  branch_target_unit branchUnit (
    .calc(calcIf.branchUnit)
  );

  assign curOpc = state_ff.instr[OPC_MSB:OPC_LSB];
  assign curSub = state_ff.instr[SUB_MSB:SUB_LSB];
  assign newOpc = instrWord[OPC_MSB:OPC_LSB];

  assign calcIf.bitOpcode = curOpc;
  assign calcIf.bitPos = state_ff.instr[BITPOS_MSB:BITPOS_LSB];
  // pins stand in for port latch
  assign calcIf.operand = fileIsPort ? pinRdData : fileRdData;
  assign calcIf.basePc = state_ff.nextPcHold;
  assign calcIf.longOffset = state_ff.instr[10:0];
  assign calcIf.shortOffset = state_ff.instr[7:0];
  assign calcIf.isLong = (curOpc == OPC_REL_LONG);

  // ==========================================================
  // Branch condition
  // condition code select
  always_comb begin
    case (curSub)
      COND_ZERO: condMet = zeroFlag;
      COND_NOT_ZERO: condMet = ~zeroFlag;
      COND_CARRY: condMet = carryFlag;
      COND_NOT_CARRY: condMet = ~carryFlag;
      COND_OVERFLOW: condMet = overflowFlag;
      COND_NOT_OVERFLOW: condMet = ~overflowFlag;
      COND_NEGATIVE: condMet = negativeFlag;
      COND_NOT_NEGATIVE: condMet = ~negativeFlag;
      default: condMet = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.execPend = 1'b0;
    nxt_state.fileRdEn = 1'b0;
    nxt_state.fileWrEn = 1'b0;
    nxt_state.prescalerClear = 1'b0;
    nxt_state.pcLoad = 1'b0;
    nxt_state.callPush = 1'b0;
    nxt_state.fastSave = 1'b0;
    nxt_state.returnPop = 1'b0;
    nxt_state.fastRestore = 1'b0;
    nxt_state.stackPushOp = 1'b0;
    nxt_state.stackPopOp = 1'b0;
    nxt_state.wregWrEn = 1'b0;
    nxt_state.irqEnableRestore = 1'b0;
    nxt_state.watchdogClear = 1'b0;
    nxt_state.standbyEnter = 1'b0;
    nxt_state.softReset = 1'b0;
    nxt_state.decimalAdjust = 1'b0;
    nxt_state.wordSquash = 1'b0;

    // Word acceptance
    if (instrValid) begin
      case (state_ff.state)
        ST_FLUSH: begin
          nxt_state.wordSquash = 1'b1;
          nxt_state.state = ST_RUN;
        end
        ST_SECOND: begin
          nxt_state.pcLoad = 1'b1;
          nxt_state.pcTarget = {instrWord[11:0], state_ff.lowTarget};
          nxt_state.callPush = state_ff.isCall;
          nxt_state.fastSave = state_ff.isCall & state_ff.fastSel;
          nxt_state.retAddr = nextPc;
          nxt_state.state = ST_RUN;
        end
        ST_RUN: begin
          nxt_state.instr = instrWord;
          nxt_state.nextPcHold = nextPc;
          nxt_state.execPend = 1'b1;
          if (newOpc == OPC_BIT_CLEAR || newOpc == OPC_BIT_SET ||
              newOpc == OPC_BIT_TOGGLE || newOpc == OPC_SKIP_CLEAR ||
              newOpc == OPC_SKIP_SET) begin
            nxt_state.fileAddr = instrWord[7:0];
            nxt_state.accessBank = instrWord[ACCESS_BIT];
            nxt_state.fileRdEn = 1'b1;
          end
        end
        default: begin
          nxt_state.state = ST_RUN;
        end
      endcase
    end

    // Execution, one clock after acceptance
    if (state_ff.execPend) begin
      case (curOpc)
        OPC_BIT_CLEAR, OPC_BIT_SET, OPC_BIT_TOGGLE: begin
          nxt_state.fileWrEn = 1'b1;
          nxt_state.fileWrData = calcIf.result;
          nxt_state.prescalerClear = fileIsTimerZero & prescalerAssigned;
        end
        OPC_SKIP_CLEAR: begin
          if (!calcIf.testedBit) begin
            nxt_state.state = ST_FLUSH;
          end
        end
        OPC_SKIP_SET: begin
          if (calcIf.testedBit) begin
            nxt_state.state = ST_FLUSH;
          end
        end
        OPC_REL_LONG: begin
          nxt_state.pcLoad = 1'b1;
          nxt_state.pcTarget = calcIf.target;
          nxt_state.state = ST_FLUSH;
          if (state_ff.instr[LONG_SEL_BIT]) begin
            nxt_state.callPush = 1'b1;
            nxt_state.retAddr = state_ff.nextPcHold;
          end
        end
        OPC_COND_GROUP: begin
          if (!state_ff.instr[LONG_SEL_BIT]) begin
            if (condMet) begin
              nxt_state.pcLoad = 1'b1;
              nxt_state.pcTarget = calcIf.target;
              nxt_state.state = ST_FLUSH;
            end
          end else if (curSub[3:1] == SUB_ABS_CALL) begin
            // hold low target and fast bit
            nxt_state.lowTarget = state_ff.instr[7:0];
            nxt_state.isCall = 1'b1;
            nxt_state.fastSel = state_ff.instr[CALL_FAST_BIT];
            nxt_state.state = ST_SECOND;
          end else if (curSub == SUB_ABS_JUMP) begin
            // wait for the upper target bits
            nxt_state.lowTarget = state_ff.instr[7:0];
            nxt_state.isCall = 1'b0;
            nxt_state.fastSel = 1'b0;
            nxt_state.state = ST_SECOND;
          end
        end
        OPC_ZERO_GROUP: begin
          if (curSub == SUB_LIT_RETURN) begin
            nxt_state.wregWrEn = 1'b1;
            nxt_state.wregData = state_ff.instr[7:0];
            nxt_state.returnPop = 1'b1;
            nxt_state.pcLoad = 1'b1;
            nxt_state.pcTarget = stackTopData;
            nxt_state.state = ST_FLUSH;
          end else if (curSub == SUB_CONTROL) begin
            case (state_ff.instr[7:0])
              CTL_NOP: begin
                nxt_state.wordSquash = 1'b0;
              end
              CTL_STANDBY: begin
                nxt_state.standbyEnter = 1'b1;
                nxt_state.timeoutFlag = 1'b1;
                nxt_state.powerDownFlag = 1'b0;
              end
              CTL_WDT_CLEAR: begin
                nxt_state.watchdogClear = 1'b1;
                nxt_state.timeoutFlag = 1'b1;
                nxt_state.powerDownFlag = 1'b1;
              end
              CTL_PUSH: begin
                nxt_state.stackPushOp = 1'b1;
              end
              CTL_POP: begin
                nxt_state.stackPopOp = 1'b1;
              end
              CTL_DECIMAL: begin
                nxt_state.decimalAdjust = 1'b1;
              end
              CTL_INT_RETURN, CTL_INT_RETURN_FAST: begin
                nxt_state.irqEnableRestore = 1'b1;
                nxt_state.fastRestore = state_ff.instr[FAST_BIT];
                nxt_state.returnPop = 1'b1;
                nxt_state.pcLoad = 1'b1;
                nxt_state.pcTarget = stackTopData;
                nxt_state.state = ST_FLUSH;
              end
              CTL_SUB_RETURN, CTL_SUB_RETURN_FAST: begin
                nxt_state.fastRestore = state_ff.instr[FAST_BIT];
                nxt_state.returnPop = 1'b1;
                nxt_state.pcLoad = 1'b1;
                nxt_state.pcTarget = stackTopData;
                nxt_state.state = ST_FLUSH;
              end
              CTL_SOFT_RESET: begin
                nxt_state.softReset = 1'b1;
              end
              default: begin
                nxt_state.softReset = 1'b0;
              end
            endcase
          end
        end
        // orphan second word is a no-op
        OPC_SECOND_WORD: begin
          nxt_state.wordSquash = 1'b0;
        end
        // Byte, literal and table ops belong elsewhere
        default: begin
          nxt_state.wordSquash = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= '0;
      state_ff.state <= ST_RUN;
      state_ff.timeoutFlag <= TIMEOUT_RST;
      state_ff.powerDownFlag <= POWER_DOWN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state record
  assign fileAddr = state_ff.fileAddr;
  assign accessBank = state_ff.accessBank;
  assign fileRdEn = state_ff.fileRdEn;
  assign fileWrEn = state_ff.fileWrEn;
  assign fileWrData = state_ff.fileWrData;
  assign prescalerClear = state_ff.prescalerClear;
  assign pcLoad = state_ff.pcLoad;
  assign pcTarget = state_ff.pcTarget;
  assign retAddr = state_ff.retAddr;
  assign callPush = state_ff.callPush;
  assign fastSave = state_ff.fastSave;
  assign returnPop = state_ff.returnPop;
  assign fastRestore = state_ff.fastRestore;
  assign stackPushOp = state_ff.stackPushOp;
  assign stackPopOp = state_ff.stackPopOp;
  assign wregWrEn = state_ff.wregWrEn;
  assign wregData = state_ff.wregData;
  assign irqEnableRestore = state_ff.irqEnableRestore;
  assign timeoutFlag = state_ff.timeoutFlag;
  assign powerDownFlag = state_ff.powerDownFlag;
  assign watchdogClear = state_ff.watchdogClear;
  assign standbyEnter = state_ff.standbyEnter;
  assign softReset = state_ff.softReset;
  assign decimalAdjust = state_ff.decimalAdjust;
  assign wordSquash = state_ff.wordSquash;

endmodule

// ==== verif/file_space_model.sv ====
// Data space model answering the decoder's file reads
`timescale 1ns/1ps
module file_space_model #(
  parameter logic [7:0] TIMER_ADDR = 8'h56,
  parameter logic [7:0] LATCH_MASK = 8'hA5,
  parameter logic [7:0] PIN_MASK = 8'h3C
) (
  // Request
  input logic [7:0] fileAddr,
  input logic fileRdEn,
  // Answer
  output logic [7:0] fileRdData,
  output logic [7:0] pinRdData,
  output logic fileIsPort,
  output logic fileIsTimerZero
);
  // ==========================================================
  // Read answers
  // Idle lines show the inverse, so a sample in the wrong cycle fails
  assign fileRdData = fileRdEn ? fileAddr ^ LATCH_MASK : ~(fileAddr ^ LATCH_MASK);
  assign pinRdData = fileRdEn ? fileAddr ^ PIN_MASK : ~(fileAddr ^ PIN_MASK);
  assign fileIsPort = (fileAddr[7:4] == 4'h8);
  assign fileIsTimerZero = (fileAddr == TIMER_ADDR);
endmodule

// ==== verif/decoder_monitor.sv ====
// Port-level checks for the instruction decoder
`timescale 1ns/1ps
module decoder_monitor
  import bitctl_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // Fetch side
  input logic instrValid,
  input logic [PC_W-1:0] stackTopData,
  // File access
  input logic fileRdEn,
  input logic fileWrEn,
  input logic prescalerClear,
  // Program counter and stack
  input logic pcLoad,
  input logic [PC_W-1:0] pcTarget,
  input logic callPush,
  input logic fastSave,
  input logic returnPop,
  input logic fastRestore,
  input logic stackPushOp,
  input logic stackPopOp,
  // Working register and system control
  input logic wregWrEn,
  input logic irqEnableRestore,
  input logic timeoutFlag,
  input logic powerDownFlag,
  input logic watchdogClear,
  input logic standbyEnter,
  input logic wordSquash
);
  default clocking mclk @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // File access
  chk_read_after_valid: assert property (fileRdEn |-> $past(instrValid))
    else $error("read without a word");
  chk_write_after_read:
    assert property (fileWrEn |-> $past(fileRdEn) && !pcLoad)
    else $error("write without its read");
  chk_prescaler_write: assert property (prescalerClear |-> fileWrEn)
    else $error("stray prescaler clear");
  // ==========================================================
  // Sequencing
  chk_squash_slot:
    assert property (wordSquash |-> $past(instrValid) && !fileRdEn && !pcLoad)
    else $error("squashed slot did work");
  chk_pc_latency:
    assert property (pcLoad |-> $past(instrValid) || $past(instrValid, 2))
    else $error("pc load without a word");
  chk_fast_save: assert property (fastSave |-> callPush && pcLoad)
    else $error("fast save outside a call");
  chk_return_target:
    assert property (returnPop |-> pcLoad && !callPush && pcTarget == $past(stackTopData))
    else $error("return target not stack top");
  chk_fast_restore: assert property (fastRestore |-> returnPop)
    else $error("fast restore outside a return");
  chk_working_register_return:
    assert property (wregWrEn |-> returnPop && !irqEnableRestore)
    else $error("stray working register write");
  chk_stack_single:
    assert property ((stackPushOp || stackPopOp) |-> $past(instrValid, 2) && !pcLoad)
    else $error("stack operation timing wrong");
  chk_sleep_flags:
    assert property ((standbyEnter || watchdogClear) |->
      timeoutFlag && (powerDownFlag == watchdogClear) && !(standbyEnter && watchdogClear))
    else $error("sleep flags wrong");
endmodule

bind bit_and_control_op_decoder decoder_monitor mon (
  .core_clk, .rst_n, .instrValid, .stackTopData, .fileRdEn, .fileWrEn, .prescalerClear,
  .pcLoad, .pcTarget, .callPush, .fastSave, .returnPop, .fastRestore, .stackPushOp,
  .stackPopOp, .wregWrEn, .irqEnableRestore, .timeoutFlag, .powerDownFlag,
  .watchdogClear, .standbyEnter, .wordSquash
);

// ==== verif/bit_and_control_op_decoder_tb.sv ====
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module bit_and_control_op_decoder_tb;
  import bitctl_pkg::*;
  localparam logic [7:0] TIMER_ADDR = 8'h56;
  localparam logic [7:0] LATCH_MASK = 8'hA5;
  localparam logic [7:0] PIN_MASK = 8'h3C;
  localparam int P_RD = 16, P_WR = 15, P_PRE = 14, P_PC = 13, P_CALL = 12, P_FS = 11;
  localparam int P_RET = 10, P_FR = 9, P_PUSH = 8, P_POP = 7, P_WORKING_REGISTER = 6, P_IRQ = 5;
  localparam int P_WDT = 4, P_SBY = 3, P_SRST = 2, P_DAW = 1, P_SQ = 0;
  logic core_clk, rst_n, instrValid, zeroFlag, carryFlag, overflowFlag, negativeFlag;
  logic prescalerAssigned, fileIsPort, fileIsTimerZero, accessBank, fileRdEn, fileWrEn;
  logic prescalerClear, pcLoad, callPush, fastSave, returnPop, fastRestore, stackPushOp;
  logic stackPopOp, wregWrEn, irqEnableRestore, timeoutFlag, powerDownFlag, watchdogClear;
  logic standbyEnter, softReset, decimalAdjust, wordSquash;
  logic [15:0] instrWord;
  logic [PC_W-1:0] nextPc, stackTopData, pcTarget, retAddr;
  logic [7:0] fileRdData, pinRdData, fileAddr, fileWrData, wregData, longLow;
  logic [16:0] pulses, seen1, seen2, exp1, exp2;
  logic squashNext, longPend, longCall, longFast, expTo, expPd;
  int fails, checks_done;
  logic [15:0] ctlTab[$] = '{16'h0000, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
    16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h00FF, 16'hF5A5, 16'hEE12, 16'h2A55};
  logic [3:0] modOps[3] = '{OPC_BIT_CLEAR, OPC_BIT_SET, OPC_BIT_TOGGLE};

  assign pulses = {fileRdEn, fileWrEn, prescalerClear, pcLoad, callPush, fastSave, returnPop,
    fastRestore, stackPushOp, stackPopOp, wregWrEn, irqEnableRestore, watchdogClear,
    standbyEnter, softReset, decimalAdjust, wordSquash};

  bit_and_control_op_decoder dut (
    .core_clk, .rst_n, .instrWord, .instrValid, .nextPc, .stackTopData, .zeroFlag,
    .carryFlag, .overflowFlag, .negativeFlag, .fileRdData, .pinRdData, .fileIsPort,
    .fileIsTimerZero, .prescalerAssigned, .fileAddr, .accessBank, .fileRdEn, .fileWrEn,
    .fileWrData, .prescalerClear, .pcLoad, .pcTarget, .retAddr, .callPush, .fastSave,
    .returnPop, .fastRestore, .stackPushOp, .stackPopOp, .wregWrEn, .wregData,
    .irqEnableRestore, .timeoutFlag, .powerDownFlag, .watchdogClear, .standbyEnter,
    .softReset, .decimalAdjust, .wordSquash
  );
  file_space_model model (
    .fileAddr, .fileRdEn, .fileRdData, .pinRdData, .fileIsPort, .fileIsTimerZero
  );

  // ==========================================================
  // Compare and report
  task cmp_pulse(string what, logic [16:0] exp, logic [16:0] got);
    cmp_val(what, {3'b0, exp}, {3'b0, got});
  endtask
  task cmp_val(string what, logic [19:0] exp, logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Reference model of one slot
  task automatic check_slot(logic [15:0] w);
    logic [7:0] opnd;
    logic [3:0] fl;
    logic bitv, taken;
    exp1 = '0;
    exp2 = '0;
    opnd = (w[7:4] == 4'h8) ? w[7:0] ^ PIN_MASK : w[7:0] ^ LATCH_MASK;
    bitv = opnd[w[11:9]];
    fl = {zeroFlag, carryFlag, overflowFlag, negativeFlag};
    taken = fl[3 - w[10:9]] ^ w[8];
    if (squashNext) begin
      exp1[P_SQ] = 1'b1;
      squashNext = 1'b0;
    end else if (longPend) begin
      exp1[P_PC] = 1'b1;
      exp1[P_CALL] = longCall;
      exp1[P_FS] = longCall & longFast;
      longPend = 1'b0;
      cmp_val("abs target", {w[11:0], longLow}, pcTarget);
      if (longCall) cmp_val("call return", nextPc, retAddr);
    end else begin
      case (w[15:12])
        4'h9, 4'h8, 4'h7: begin
          opnd[w[11:9]] = (w[15:12] == 4'h8) | ((w[15:12] == 4'h7) & ~bitv);
          exp1[P_RD] = 1'b1;
          exp2[P_WR] = 1'b1;
          exp2[P_PRE] = (w[7:0] == TIMER_ADDR) & prescalerAssigned;
          cmp_val("file address", w[8:0], {accessBank, fileAddr});
          cmp_val("write data", opnd, fileWrData);
        end
        4'hB, 4'hA: begin
          exp1[P_RD] = 1'b1;
          squashNext = bitv ^ (w[15:12] == 4'hB);
        end
        4'hE: begin
          if (!w[11]) begin
            exp2[P_PC] = taken;
            squashNext = taken;
            if (taken) cmp_val("bcc target", nextPc + {{12{w[7]}}, w[7:0]}, pcTarget);
          end else if (w[10:9] == 2'b10 || w[11:8] == 4'hF) begin
            longPend = 1'b1;
            longCall = (w[10:9] == 2'b10);
            longFast = w[8];
            longLow = w[7:0];
          end
        end
        4'hD: begin
          exp2[P_PC] = 1'b1;
          exp2[P_CALL] = w[11];
          squashNext = 1'b1;
          cmp_val("rel target", nextPc + {{9{w[10]}}, w[10:0]}, pcTarget);
          if (w[11]) cmp_val("rel return", nextPc, retAddr);
        end
        4'h0: begin
          if (w[11:8] == 4'hC || w[11:2] == 10'h004) begin
            exp2[P_PC] = 1'b1;
            exp2[P_RET] = 1'b1;
            exp2[P_FR] = (w[11:8] == 4'h0) & w[0];
            exp2[P_WORKING_REGISTER] = (w[11:8] == 4'hC);
            exp2[P_IRQ] = (w[11:1] == 11'h008);
            squashNext = 1'b1;
            cmp_val("return target", stackTopData, pcTarget);
            if (w[11:8] == 4'hC) cmp_val("literal", w[7:0], wregData);
          end else if (w[11:8] == 4'h0) begin
            exp2[P_SBY] = (w[7:0] == CTL_STANDBY);
            exp2[P_WDT] = (w[7:0] == CTL_WDT_CLEAR);
            exp2[P_PUSH] = (w[7:0] == CTL_PUSH);
            exp2[P_POP] = (w[7:0] == CTL_POP);
            exp2[P_DAW] = (w[7:0] == CTL_DECIMAL);
            exp2[P_SRST] = (w[7:0] == CTL_SOFT_RESET);
            expTo = expTo | exp2[P_SBY] | exp2[P_WDT];
            expPd = (expPd & ~exp2[P_SBY]) | exp2[P_WDT];
          end
        end
        default: ;
      endcase
    end
    cmp_val("status flags", {expTo, expPd}, {timeoutFlag, powerDownFlag});
    cmp_pulse("first cycle", exp1, seen1);
    cmp_pulse("second cycle", exp2, seen2);
  endtask

  // ==========================================================
  // Stimulus
  // Three clocks a slot, above the minimum spacing
  task slot(logic [15:0] w);
    instrWord <= w;
    instrValid <= 1'b1;
    nextPc <= PC_W'($urandom);
    stackTopData <= PC_W'($urandom);
    {zeroFlag, carryFlag, overflowFlag, negativeFlag} <= 4'($urandom);
    prescalerAssigned <= 1'($urandom);
    @(posedge core_clk);
    instrValid <= 1'b0;
    @(negedge core_clk);
    seen1 = pulses;
    @(negedge core_clk);
    seen2 = pulses;
    check_slot(w);
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] gen();
    logic [15:0] r;
    r = 16'($urandom);
    if (longPend) return {4'hF, r[11:0]};
    case (r[15:13])
      3'd0: return {modOps[r[1:0] % 3], r[11:0]};
      3'd1: return {modOps[r[1:0] % 3], r[11:8], TIMER_ADDR};
      3'd2: return {modOps[r[1:0] % 3], r[11:8], 4'h8, r[3:0]};
      3'd3: return {r[12] ? OPC_SKIP_CLEAR : OPC_SKIP_SET, r[11:8], 1'b0, r[6:0]};
      3'd4: return {4'hE, 1'b0, r[10:0]};
      3'd5: return {4'hD, r[11:0]};
      3'd6: return {4'hE, r[12] ? 4'hF : {3'b110, r[8]}, r[7:0]};
      default: return r[12] ? {8'h0C, r[7:0]} : ctlTab[r[11:8] % ctlTab.size()];
    endcase
  endfunction
  task do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    squashNext = 1'b0;
    longPend = 1'b0;
    expTo = 1'b1;
    expPd = 1'b1;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    instrValid = 1'b0;
    instrWord = '0;
    nextPc = '0;
    stackTopData = '0;
    {zeroFlag, carryFlag, overflowFlag, negativeFlag} = 4'h0;
    prescalerAssigned = 1'b0;
    fails = 0;
    checks_done = 0;
    void'($urandom(32'hCC61BF19));
    @(posedge core_clk);
    do_reset();
    // Each control word, then a no-op a return may squash
    foreach (ctlTab[i]) begin
      slot(ctlTab[i]);
      slot(16'h0000);
    end
    // Skip a two-word call: first word squashed, second a no-op
    slot({OPC_SKIP_SET, 4'h0, 8'h10});
    slot(16'hEC34);
    slot(16'hF123);
    repeat (300) slot(gen());
    // No-op soaks up a pending squash, then standby before reset
    slot(16'h0000);
    slot(16'h0003);
    do_reset();
    repeat (300) slot(gen());
    end_sim();
  end
endmodule
